// file: rtl/pim_in_filter.sv
`timescale 1ns/1ps
module pim_in_filter
  import pim_pkg::*;
#(
  parameter int WIDTH      = PIM_FILT_W,
  parameter int STABLE_CYC = PIM_FILT_CYC
)
(
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] raw_in,
  output logic      [WIDTH-1:0] filt_out
);
  localparam int CW = $clog2(STABLE_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(STABLE_CYC - 1);

  if (WIDTH < 1 || STABLE_CYC < 1)
  begin : g_chk
    $error("pim_in_filter: bad parameters");
  end

  logic [WIDTH-1:0] sync1_q, sync2_q, filt_q, filt_d;
  logic [CW-1:0]    cnt_q [WIDTH];
  logic [CW-1:0]    cnt_d [WIDTH];

  // a level must stay changed for STABLE_CYC cycles before it is taken
  always_comb
  begin
    filt_d = filt_q;
    for (int i = 0; i < WIDTH; i++)
    begin
      cnt_d[i] = '0;
      if (sync2_q[i] != filt_q[i])
      begin
        if (cnt_q[i] == CNT_LAST)
          filt_d[i] = sync2_q[i];
        else
          cnt_d[i] = cnt_q[i] + CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      filt_q  <= '0;
      for (int i = 0; i < WIDTH; i++)
        cnt_q[i] <= '0;
    end
    else
    begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      filt_q  <= filt_d;
      for (int i = 0; i < WIDTH; i++)
        cnt_q[i] <= cnt_d[i];
    end
  end

  assign filt_out = filt_q;
endmodule

// file: rtl/pim_io_map.sv
`timescale 1ns/1ps
module pim_io_map
  import pim_pkg::*;
#(
  parameter int CNT_W      = 16,
  parameter int FILT_CYC   = PIM_FILT_CYC,
  parameter int ACK_CYC    = PIM_ACK_CYC
)
(
  input  wire logic                     sys_clk,
  input  wire logic                     reset,
  input  pim_profile_t                  profile_sel,
  input  wire logic [PIM_IN_PORTS-1:0]  in_port,
  input  wire logic                     aux_start_npn_n,
  input  wire logic                     aux_start_pnp,
  input  wire logic                     aux_start_contact,
  input  wire logic                     core_error,
  input  wire logic                     core_ribbon_fault,
  input  wire logic                     core_order_active,
  input  wire logic                     core_layout_ready,
  input  wire logic                     core_layout_busy,
  input  wire logic                     core_printing,
  input  wire logic                     core_head_up,
  input  wire logic                     core_returning,
  input  wire logic                     core_ribbon_low,
  output logic      [PIM_OUT_PORTS-1:0] out_conduct,
  output logic                          aux_error_lamp,
  output logic                          print_start_cmd,
  output logic                          start_refused,
  output logic                          error_reset_cmd,
  output logic                          counter_clear_cmd,
  output logic                          file_load_cmd,
  output logic      [PIM_FNUM_W-1:0]    file_num,
  output logic      [CNT_W-1:0]         print_count
);
  localparam int AW = $clog2(ACK_CYC + 1);
  localparam logic [AW-1:0]    ACK_LAST = AW'(ACK_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  if (CNT_W < 1)
  begin : g_chk_cnt
    $error("pim_io_map: counter width must be at least 1");
  end

  if (ACK_CYC < 1)
  begin : g_chk_ack
    $error("pim_io_map: acknowledge wait must be at least 1 cycle");
  end

  if (FILT_CYC < 1)
  begin : g_chk_filt
    $error("pim_io_map: filter time must be at least 1 cycle");
  end

  // the file number has to fit inside the eight input ports
  if (PIM_FNUM_LSB + PIM_FNUM_W > PIM_IN_PORTS)
  begin : g_chk_fnum
    $error("pim_io_map: file number field exceeds the input ports");
  end

  typedef enum logic [1:0] {
    PIM_ST_IDLE = 2'h0,
    PIM_ST_WAIT = 2'h1,
    PIM_ST_RUN  = 2'h2
  } pim_state_t;

  // role decode of the filtered input ports for one profile
  function automatic pim_cmd_t decode_inputs(input pim_profile_t prof,
                                             input logic [PIM_FILT_W-1:0] f);
    pim_cmd_t c;
    logic     aux;
    // npn arrives already inverted, so all three aux starts are active high
    aux     = f[PIM_AUX_NPN] | f[PIM_AUX_PNP] | f[PIM_AUX_CONT];
    c.start = f[PIM_IN_START] | aux;
    c.fnum  = '0;
    case (prof)
      PIM_PROF_FIXED:
      begin
        // ports 2 and 5, the error reset inputs, are left unread here
        c.err_rst = 1'b0;
        c.cnt_rst = f[PIM_IN_P3];
      end
      PIM_PROF_FSEL:
      begin
        c.err_rst = f[PIM_IN_P2];
        c.cnt_rst = 1'b0;
        c.fnum    = f[PIM_FNUM_LSB +: PIM_FNUM_W];
      end
      default:
      begin
        // unknown codes fall back to the standard profile
        c.err_rst = f[PIM_IN_P2] | f[PIM_IN_P5];
        c.cnt_rst = f[PIM_IN_P3];
      end
    endcase
    return c;
  endfunction

  logic [PIM_FILT_W-1:0] raw_in, filt;
  pim_cmd_t              cmd;
  pim_status_t           status;
  logic                  accept_ok;

  // the npn pin is active low; inverting it ahead of the filter makes the
  // filter's cleared state the idle level, so reset cannot fake a start
  assign raw_in = {aux_start_contact, aux_start_pnp, ~aux_start_npn_n, in_port};

  pim_in_filter #(
    .WIDTH      (PIM_FILT_W),
    .STABLE_CYC (FILT_CYC)
  ) u_filter (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .raw_in   (raw_in),
    .filt_out (filt)
  );

  assign cmd = decode_inputs(profile_sel, filt);

  // one-cycle pulse on a low-to-high change of a filtered role
  function automatic logic rise(input logic now_v,
                                input logic was_v);
    return now_v & ~was_v;
  endfunction

  // edge detectors and command pulses; histories reset low, the idle level of every role
  logic start_q, start_d;
  logic erst_q, erst_d;
  logic crst_q, crst_d;
  logic start_rise, erst_rise, crst_rise;

  always_comb
  begin
    start_d = cmd.start;
    erst_d  = cmd.err_rst;
    crst_d  = cmd.cnt_rst;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      start_q <= 1'b0;
      erst_q  <= 1'b0;
      crst_q  <= 1'b0;
    end
    else
    begin
      start_q <= start_d;
      erst_q  <= erst_d;
      crst_q  <= crst_d;
    end
  end

  assign start_rise = rise(cmd.start, start_q);
  assign erst_rise  = rise(cmd.err_rst, erst_q);
  assign crst_rise  = rise(cmd.cnt_rst, crst_q);

  // print order sequencing
  pim_state_t      state_q, state_d;
  logic [AW-1:0]   ack_q, ack_d;
  logic            pstart_q, pstart_d;
  logic            refuse_q, refuse_d;
  logic            eclr_q, eclr_d;
  logic            cclr_q, cclr_d;
  logic            fload_q, fload_d;
  logic [PIM_FNUM_W-1:0] fnum_q, fnum_d;
  logic [CNT_W-1:0]      cnt_q, cnt_d;
  logic                  err_any;

  assign err_any = core_error | core_ribbon_fault;

  // ready also waits out layout generation and carriage return
  always_comb
  begin
    accept_ok = (state_q == PIM_ST_IDLE);
    if (err_any | core_order_active | core_layout_busy)
      accept_ok = 1'b0;
    if (core_printing | core_returning)
      accept_ok = 1'b0;
  end

  always_comb
  begin
    state_d  = state_q;
    ack_d    = ack_q;
    pstart_d = 1'b0;
    refuse_d = 1'b0;
    eclr_d   = erst_rise;
    cclr_d   = crst_rise;
    fload_d  = 1'b0;
    fnum_d   = fnum_q;
    cnt_d    = cnt_q;
    case (state_q)
      PIM_ST_IDLE:
      begin
        ack_d = '0;
        if (start_rise)
        begin
          if (accept_ok)
          begin
            pstart_d = 1'b1;
            state_d  = PIM_ST_WAIT;
            if (profile_sel == PIM_PROF_FSEL)
            begin
              fnum_d  = cmd.fnum;
              fload_d = 1'b1;
            end
          end
          else
            refuse_d = 1'b1;
        end
      end
      PIM_ST_WAIT:
      begin
        // a core that never confirms must not lock out later starts
        if (start_rise)
          refuse_d = 1'b1;
        if (core_order_active)
          state_d = PIM_ST_RUN;
        else if (ack_q == ACK_LAST)
          state_d = PIM_ST_IDLE;
        else
          ack_d = ack_q + AW'(1);
      end
      PIM_ST_RUN:
      begin
        if (start_rise)
          refuse_d = 1'b1;
        if (~core_order_active)
          state_d = PIM_ST_IDLE;
      end
      default:
      begin
        state_d = PIM_ST_IDLE;
      end
    endcase
    // a start in the clearing cycle still counts, so the count restarts at one
    if (crst_rise)
      cnt_d = pstart_d ? CNT_ONE : '0;
    else if (pstart_d)
      cnt_d = cnt_q + CNT_ONE;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_q  <= PIM_ST_IDLE;
      ack_q    <= '0;
      pstart_q <= 1'b0;
      refuse_q <= 1'b0;
      eclr_q   <= 1'b0;
      cclr_q   <= 1'b0;
      fload_q  <= 1'b0;
      fnum_q   <= '0;
      cnt_q    <= '0;
    end
    else
    begin
      state_q  <= state_d;
      ack_q    <= ack_d;
      pstart_q <= pstart_d;
      refuse_q <= refuse_d;
      eclr_q   <= eclr_d;
      cclr_q   <= cclr_d;
      fload_q  <= fload_d;
      fnum_q   <= fnum_d;
      cnt_q    <= cnt_d;
    end
  end

  always_comb
  begin
    status.error        = err_any;
    status.order_active = core_order_active;
    status.layout_ready = core_layout_ready;
    status.printing     = core_printing;
    status.ready        = accept_ok;
    status.head_up      = core_head_up;
    status.returning    = core_returning;
    status.ribbon_low   = core_ribbon_low;
  end

  // the map registers every port, so each one lags its status by one cycle
  pim_out_map u_out_map (
    .sys_clk (sys_clk),
    .reset   (reset),
    .profile (profile_sel),
    .status  (status),
    .conduct (out_conduct),
    .lamp    (aux_error_lamp)
  );

  assign print_start_cmd   = pstart_q;
  assign start_refused     = refuse_q;
  assign error_reset_cmd   = eclr_q;
  assign counter_clear_cmd = cclr_q;
  assign file_load_cmd     = fload_q;
  assign file_num          = fnum_q;
  assign print_count       = cnt_q;
endmodule

// file: rtl/pim_out_map.sv
`timescale 1ns/1ps
module pim_out_map
  import pim_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     reset,
  input  pim_profile_t                  profile,
  input  pim_status_t                   status,
  output logic      [PIM_OUT_PORTS-1:0] conduct,
  output logic                          lamp
);
  logic [PIM_OUT_PORTS-1:0] conduct_d, conduct_q;
  logic                     lamp_d, lamp_q;

  // index 0 is port 9; a high bit closes the optocoupler switch
  always_comb
  begin
    conduct_d[0] = status.error;
    conduct_d[1] = status.order_active;
    conduct_d[2] = status.layout_ready;
    conduct_d[3] = status.printing;
    conduct_d[4] = status.ready;
    conduct_d[6] = status.returning;
    conduct_d[7] = status.ribbon_low;
    case (profile)
      PIM_PROF_FIXED: conduct_d[5] = status.head_up;
      PIM_PROF_STD:   conduct_d[5] = status.error;
      PIM_PROF_FSEL:  conduct_d[5] = status.error;
      default:        conduct_d[5] = status.error;
    endcase
    lamp_d = status.error;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      conduct_q <= '0;
      lamp_q    <= 1'b0;
    end
    else
    begin
      conduct_q <= conduct_d;
      lamp_q    <= lamp_d;
    end
  end

  assign conduct = conduct_q;
  assign lamp    = lamp_q;
endmodule

// file: rtl/pim_pkg.sv
package pim_pkg;

  typedef enum logic [1:0] {
    PIM_PROF_STD   = 2'h0,
    PIM_PROF_FSEL  = 2'h1,
    PIM_PROF_FIXED = 2'h2
  } pim_profile_t;

  // input port indices, port 1 at index 0
  localparam int PIM_IN_START  = 0;
  localparam int PIM_IN_P2     = 1;
  localparam int PIM_IN_P3     = 2;
  localparam int PIM_IN_P5     = 4;
  localparam int PIM_FNUM_LSB  = 2;
  localparam int PIM_FNUM_W    = 6;
  localparam int PIM_IN_PORTS  = 8;
  localparam int PIM_OUT_PORTS = 8;
  // aux connector bits follow the eight ports in the filter
  localparam int PIM_AUX_NPN   = 8;
  localparam int PIM_AUX_PNP   = 9;
  localparam int PIM_AUX_CONT  = 10;
  localparam int PIM_FILT_W    = 11;

  localparam int PIM_CLK_MHZ       = 50;
  localparam int PIM_FILT_TIME_US  = 10;
  localparam int PIM_FILT_CYC      = PIM_FILT_TIME_US * PIM_CLK_MHZ;
  localparam int PIM_ACK_TIME_US   = 20;
  localparam int PIM_ACK_CYC       = PIM_ACK_TIME_US * PIM_CLK_MHZ;

  typedef struct packed {
    logic ribbon_low;
    logic returning;
    logic head_up;
    logic ready;
    logic printing;
    logic layout_ready;
    logic order_active;
    logic error;
  } pim_status_t;

  typedef struct packed {
    logic                  start;
    logic                  err_rst;
    logic                  cnt_rst;
    logic [PIM_FNUM_W-1:0] fnum;
  } pim_cmd_t;

endpackage

// file: testbench/pim_host_model.sv
`timescale 1ns/1ps
module pim_host_model
  import pim_pkg::*;
(
  input  wire logic                    sys_clk,
  output logic      [PIM_IN_PORTS-1:0] in_port,
  output logic                         aux_start_npn_n,
  output logic                         aux_start_pnp,
  output logic                         aux_start_contact
);
  initial
  begin
    in_port = 8'h00;
    aux_start_npn_n = 1'b1;
    aux_start_pnp = 1'b0;
    aux_start_contact = 1'b0;
  end

  // data lines settle before start rises and stay after it drops
  task automatic press(input logic [10:0] pins, input int hold);
    @(posedge sys_clk);
    in_port <= pins[7:0] & 8'hFE;
    repeat (4) @(posedge sys_clk);
    in_port <= pins[7:0];
    aux_start_npn_n <= !pins[8];
    aux_start_pnp <= pins[9];
    aux_start_contact <= pins[10];
    repeat (hold) @(posedge sys_clk);
    in_port <= pins[7:0] & 8'hFE;
    aux_start_npn_n <= 1'b1;
    aux_start_pnp <= 1'b0;
    aux_start_contact <= 1'b0;
    repeat (4) @(posedge sys_clk);
    in_port <= 8'h00;
  endtask
endmodule

// file: testbench/pim_io_map_sva.sv
`timescale 1ns/1ps
module pim_io_map_sva
  import pim_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic                     sys_clk,
  input wire logic                     reset,
  input pim_profile_t                  profile_sel,
  input wire logic                     core_error,
  input wire logic                     core_ribbon_fault,
  input wire logic                     core_order_active,
  input wire logic                     core_layout_ready,
  input wire logic                     core_printing,
  input wire logic                     core_head_up,
  input wire logic                     core_returning,
  input wire logic                     core_ribbon_low,
  input wire logic [PIM_OUT_PORTS-1:0] out_conduct,
  input wire logic                     aux_error_lamp,
  input wire logic                     print_start_cmd,
  input wire logic                     start_refused,
  input wire logic                     counter_clear_cmd,
  input wire logic                     file_load_cmd,
  input wire logic [PIM_FNUM_W-1:0]    file_num,
  input wire logic [CNT_W-1:0]         print_count
);
  logic [1:0] up_q;
  logic [1:0] up_d;
  logic       err;
  logic       up;

  // first edges after reset still carry reset values, so mapping checks wait
  assign err = core_error | core_ribbon_fault;
  assign up  = (up_q == 2'h3);
  always_comb up_d = up ? up_q : up_q + 2'h1;
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      up_q <= 2'h0;
    else
      up_q <= up_d;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_err_port: assert property (up |-> out_conduct[0] == $past(err))
    else $error("error port wrong");
  a_mid_ports: assert property (up |-> out_conduct[3:1] ==
    $past({core_printing, core_layout_ready, core_order_active}))
    else $error("ports 10 to 12 wrong");
  a_head_port: assert property (up |-> out_conduct[5] ==
    $past(profile_sel == PIM_PROF_FIXED ? core_head_up : err))
    else $error("port 14 wrong");
  a_tail_ports: assert property (up |-> out_conduct[7:6] ==
    $past({core_ribbon_low, core_returning}))
    else $error("ports 15 and 16 wrong");
  a_ready_excl: assert property (out_conduct[4] |-> !(out_conduct[0] | out_conduct[1] |
    out_conduct[3] | out_conduct[6]))
    else $error("ready while busy");
  a_ready_drop: assert property (print_start_cmd |-> ##[1:2] !out_conduct[4])
    else $error("ready stays after start");
  a_lamp_err: assert property (aux_error_lamp == out_conduct[0])
    else $error("lamp differs from error port");
  a_count_step: assert property (print_start_cmd && !counter_clear_cmd |->
    print_count == CNT_W'($past(print_count) + 1))
    else $error("count not stepped");
  a_count_clear: assert property (counter_clear_cmd |->
    print_count == CNT_W'(print_start_cmd))
    else $error("count not cleared");
  a_count_hold: assert property (up && !print_start_cmd && !counter_clear_cmd |->
    $stable(print_count))
    else $error("count moved");
  a_load_pair: assert property (file_load_cmd ==
    (print_start_cmd && $past(profile_sel) == PIM_PROF_FSEL))
    else $error("file load mismatch");
  a_fnum_hold: assert property (up && !file_load_cmd |-> $stable(file_num))
    else $error("file number moved");
  a_one_outcome: assert property (!(print_start_cmd && start_refused))
    else $error("start both taken and refused");
  a_start_pulse: assert property (print_start_cmd |=> !print_start_cmd)
    else $error("start pulse too long");

  c_start: cover property (print_start_cmd);
  c_refused: cover property (start_refused);
  c_load: cover property (file_load_cmd);
  c_clear: cover property (counter_clear_cmd && print_start_cmd);
endmodule

bind pim_io_map pim_io_map_sva #(.CNT_W(CNT_W)) u_sva (.*);

// file: testbench/print_module_io_profile_map_tb_top.sv
`timescale 1ns/1ps
module print_module_io_profile_map_tb_top;
  import pim_pkg::*;
  logic                     sys_clk;
  logic                     reset;
  pim_profile_t             prof;
  logic [8:0]               core;
  logic [PIM_IN_PORTS-1:0]  in_port;
  logic                     npn_n, pnp, contact;
  logic [PIM_OUT_PORTS-1:0] out_conduct;
  logic                     lamp, start_cmd, refused, err_rst, cnt_clr, fload;
  logic [PIM_FNUM_W-1:0]    file_num, fnum;
  logic [15:0]              print_count, cnt;
  logic [10:0]              last;
  int                       bad_count, n_tests;
  localparam int            FILT = 2;

  pim_io_map #(.FILT_CYC(FILT), .ACK_CYC(8)) u_dut (
    .sys_clk(sys_clk), .reset(reset), .profile_sel(prof), .in_port(in_port),
    .aux_start_npn_n(npn_n), .aux_start_pnp(pnp), .aux_start_contact(contact),
    .core_error(core[0]), .core_ribbon_fault(core[1]), .core_order_active(core[2]),
    .core_layout_ready(core[3]), .core_layout_busy(core[4]), .core_printing(core[5]),
    .core_head_up(core[6]), .core_returning(core[7]), .core_ribbon_low(core[8]),
    .out_conduct(out_conduct), .aux_error_lamp(lamp), .print_start_cmd(start_cmd),
    .start_refused(refused), .error_reset_cmd(err_rst), .counter_clear_cmd(cnt_clr),
    .file_load_cmd(fload), .file_num(file_num), .print_count(print_count));

  pim_host_model u_host (.sys_clk(sys_clk), .in_port(in_port), .aux_start_npn_n(npn_n),
    .aux_start_pnp(pnp), .aux_start_contact(contact));

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // {lamp, ports 16 down to 9}; ready assumes no print order is in progress
  function automatic logic [8:0] exp_out(input logic [8:0] c, input logic [1:0] p);
    logic e;
    e = c[0] | c[1];
    return {e, c[8], c[7], (p == 2'h2) ? c[6] : e, !(e | c[2] | c[4] | c[5] | c[7]),
            c[5], c[3], c[2], e};
  endfunction

  // {start, refused, error reset, counter clear, file load}; unknown profile acts standard
  function automatic logic [4:0] exp_cmd(input logic [1:0] p, input logic [10:0] s,
                                         input int hold, input logic busy);
    logic st, fs, fx;
    fs = (p == 2'h1);
    fx = (p == 2'h2);
    st = (s[0] | (|s[10:8])) && hold >= FILT;
    return {st & !busy, st & busy, !fx & (s[1] | (!fs & s[4])), !fs & s[2], st & !busy & fs};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic watch(input int n, output logic [4:0] seen);
    seen = 5'h00;
    repeat (n)
    begin
      @(negedge sys_clk);
      seen = seen | {start_cmd, refused, err_rst, cnt_clr, fload};
    end
  endtask

  task automatic run_case(input logic [1:0] p, input logic [10:0] s, input int hold,
                          input logic busy);
    logic [4:0] exp, seen;
    exp = exp_cmd(p, s, hold, busy);
    @(posedge sys_clk);
    prof <= pim_profile_t'(p);
    core[7] <= busy;
    fork
      u_host.press(s, hold);
      watch(30, seen);
    join
    check("commands", seen, exp);
    cnt = exp[1] ? 16'(exp[4]) : cnt + 16'(exp[4]);
    if (exp[0])
      fnum = s[7:2];
    check("print_count", print_count, cnt);
    check("file_num", file_num, fnum);
    $display("case done profile %0d pins %0h", p, s);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    reset = 1'b1;
    prof = PIM_PROF_STD;
    core = 9'h000;
    bad_count = 0;
    n_tests = 0;
    cnt = 16'h0000;
    fnum = 6'h00;
    void'($urandom(32'hBC50));
    repeat (20) @(posedge sys_clk);
    check("reset_outputs", {out_conduct, print_count}, 32'h0);
    reset <= 1'b0;
    last = 11'h000;
    repeat (150)
    begin
      @(posedge sys_clk);
      core <= 9'($urandom);
      prof <= pim_profile_t'($urandom_range(3, 0));
      @(negedge sys_clk);
      check("status_map", {lamp, out_conduct},
            exp_out(last[10:2], last[1:0]));
      last = {core, 2'(prof)};
    end
    $display("status mapping done");
    @(posedge sys_clk);
    core <= 9'h000;
    repeat (3) @(posedge sys_clk);
    run_case(2'h1, 11'h0FD, 6, 1'b0);
    run_case(2'h1, 11'h001, 6, 1'b0);
    run_case(2'h0, 11'h005, 6, 1'b0);
    run_case(2'h0, 11'h012, 6, 1'b0);
    run_case(2'h2, 11'h00A, 6, 1'b0);
    run_case(2'h2, 11'h100, 6, 1'b0);
    run_case(2'h3, 11'h200, 6, 1'b0);
    run_case(2'h1, 11'h400, 6, 1'b0);
    run_case(2'h0, 11'h001, 1, 1'b0);
    run_case(2'h1, 11'h0A9, 6, 1'b1);
    repeat (12) run_case(2'($urandom), 11'($urandom), 6, 1'($urandom_range(1, 0)));
    end_sim();
  end
endmodule
